// ---- inc/boc_params.svh ----
// Register map, field positions, reset values and timing counts of the
// breaker object controller.
// Assumes a 125 MHz core clock and a 32-bit APB register bus.
//
// Summary of operation
// - Open-status input at 1 means the object is open.
// - Close-status input at 1 means the object is closed.
// - Cart-in input at 1 means the withdrawable cart is inserted.
// - Cart-out input at 1 means the withdrawable cart is withdrawn.
// - Ready input at 1 means closing spring charged, close may be accepted.
// - Sync permission at 1 means synchronism met, closing permitted.
// - Open and close commands are pulses on separate outputs.
// - Both positions still active after traverse time gives status Bad.
// - Neither position active after traverse time gives status Intermediate.
// - Close pulse limited to a set length, ended early once closed.
// - Open pulse limited to its own set length, ended early once open.
// - No status change within termination timeout ends control with error.
// - Final trip output pulses for set length; zero length means continuous.
// - Final trip only when no further automatic reclose is expected.
// - Panel control gated by required access level, configurator by default.
// - Local, remote and application command sources, each selectable.
// - Separate blocking and interlock conditions for open and close.
// - With sync check in use, close issued only while permission active.
// - Ready condition selectable high, low or unused, required before close.
// - Four 32-bit request counters; clear zeroes them and self-returns.
`ifndef BOC_PARAMS_SVH
`define BOC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BOC_ADDR_CTRL 8'h00
`define BOC_ADDR_CMD 8'h04
`define BOC_ADDR_TRAV 8'h08
`define BOC_ADDR_CPULSE 8'h0c
`define BOC_ADDR_OPULSE 8'h10
`define BOC_ADDR_TERM 8'h14
`define BOC_ADDR_FTRIP 8'h18
`define BOC_ADDR_STATUS 8'h1c
`define BOC_ADDR_STAT0 8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BOC_CTRL_SYNC 0
`define BOC_CTRL_RDY_LSB 1
`define BOC_CTRL_ACC_LSB 3
`define BOC_CTRL_SRC_LSB 5
`define BOC_CTRL_CLR 8
`define BOC_CMD_OPEN 0
`define BOC_CMD_CLOSE 1
`define BOC_CMD_LVL_LSB 2

// ----------------------------------------------------------------------
// Reset values (times in 20 ms steps)
// ----------------------------------------------------------------------
`define BOC_RST_RDY 2'h2
`define BOC_RST_ACC 2'h2
`define BOC_RST_SRC 3'h7
`define BOC_RST_TRAV 15'h000a
`define BOC_RST_CPULSE 15'h000a
`define BOC_RST_OPULSE 15'h000a
`define BOC_RST_TERM 15'h01f4
`define BOC_RST_FTRIP 15'h000a

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BOC_CLK_NS 8
`define BOC_TICK_NS 1000000
`define BOC_TICK_CYC (`BOC_TICK_NS / `BOC_CLK_NS)
`define BOC_STEP_MS 20'h00014
`define BOC_BLOCK_LEAD_MS 5

`endif

// ---- inc/boc_pkg.sv ----
// Types shared by the breaker object controller modules.
// Assumes boc_params.svh supplies all numeric constants.
package boc_pkg;
    // Position status of a two-input monitored object
    typedef enum logic [1:0] {
        BOC_POS_MID = 2'h0,
        BOC_POS_OPEN = 2'h1,
        BOC_POS_CLOSED = 2'h2,
        BOC_POS_BAD = 2'h3
    } boc_pos_t;

    // Control sequencer, one-hot
    typedef enum logic [2:0] {
        BOC_ST_IDLE = 3'h1,
        BOC_ST_OPENING = 3'h2,
        BOC_ST_CLOSING = 3'h4
    } boc_state_t;

    // Ready condition selection
    typedef enum logic [1:0] {
        BOC_RDY_HIGH = 2'h0,
        BOC_RDY_LOW = 2'h1,
        BOC_RDY_OFF = 2'h2
    } boc_rdy_t;
endpackage

// ---- inc/boc_pos_if.sv ----
// Carrier between the controller and a position monitor.
// Assumes boc_pkg is compiled first.
`timescale 1ns/1ps
interface boc_pos_if;
    logic open_in;
    logic close_in;
    logic [14:0] trav;
    boc_pkg::boc_pos_t status;
    modport mon(input open_in, input close_in, input trav, output status);
    modport user(output open_in, output close_in, output trav, input status);
endinterface

// ---- hw/boc_tick_gen.sv ----
// Millisecond tick generator.
// Assumes CYCLES is at least 2.
`timescale 1ns/1ps
`include "boc_params.svh"
module boc_tick_gen #(
    parameter int CYCLES = `BOC_TICK_CYC
) (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    output logic tick // One-cycle pulse each millisecond
);
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] cnt_q;
    wire wrap = (cnt_q == W'(CYCLES - 1));

    // Free-running divider
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + W'(1);
            tick <= wrap;
        end
    end
endmodule

// ---- hw/boc_pos_mon.sv ----
// Position monitor: resolves two status inputs into open, closed,
// intermediate or bad, using a traverse time in 20 ms steps.
// Assumes a 1 ms tick from boc_tick_gen.
`timescale 1ns/1ps
`include "boc_params.svh"
module boc_pos_mon (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic tick, // 1 ms tick
    boc_pos_if.mon pos // Inputs, traverse setting and status
);
    import boc_pkg::*;
    logic [1:0] pat_q;
    logic [19:0] cnt_q;
    boc_pos_t st_q;
    wire [1:0] pat = {pos.close_in, pos.open_in};
    wire [19:0] lim = 20'(pos.trav) * `BOC_STEP_MS;
    // A fresh pattern must not inherit the old elapsed time
    wire elapsed = (pat == pat_q) && (cnt_q >= lim);
    wire boc_pos_t st_d = (pat == 2'b01) ? BOC_POS_OPEN :
                         (pat == 2'b10) ? BOC_POS_CLOSED :
                         !elapsed ? st_q :
                         (pat == 2'b11) ? BOC_POS_BAD : BOC_POS_MID;

    // Status holds during travel; the timer restarts on every change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pat_q <= 2'h0;
            cnt_q <= 20'h0;
            st_q <= BOC_POS_MID;
        end else begin
            pat_q <= pat;
            st_q <= st_d;
            if (pat != pat_q)
                cnt_q <= 20'h0;
            else if (tick && !elapsed)
                cnt_q <= cnt_q + 20'h1;
        end
    end

    assign pos.status = st_q;
endmodule

// ---- hw/boc_object_ctrl.sv ----
// Breaker object controller: command sources, interlocks, close
// conditions, timed open and close pulses, termination timeout, final
// trip and request statistics, with an APB register file.
// Assumes all inputs synchronous to CORE_CLK and an APB master.
`timescale 1ns/1ps
`include "boc_params.svh"
module boc_object_ctrl #(
    parameter int TICK_CYCLES = `BOC_TICK_CYC
) (
    input wire logic CORE_CLK, // 125 MHz core clock
    input wire logic NRST, // Synchronous reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction, 1 write
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic OPEN_ST, // Object open status
    input wire logic CLOSE_ST, // Object close status
    input wire logic CART_INSERTED_IN, // Cart inserted status
    input wire logic CART_WITHDRAWN_IN, // Cart withdrawn status
    input wire logic READY_ST, // Spring charged, ready to close
    input wire logic SYNC_OK, // Synchrocheck permission
    input wire logic LOC_OPEN, // Local open request
    input wire logic LOC_CLOSE, // Local close request
    input wire logic REM_OPEN, // Remote open request
    input wire logic REM_CLOSE, // Remote close request
    input wire logic APP_OPEN, // Application open request
    input wire logic APP_CLOSE, // Application close request
    input wire logic BLOCK_OPEN, // Open blocking or interlock
    input wire logic BLOCK_CLOSE, // Close blocking or interlock
    input wire logic RECLOSE_PENDING, // Further autoreclose expected
    output logic OPEN_CMD, // Open command pulse to relay
    output logic CLOSE_CMD, // Close command pulse to relay
    output logic FINAL_TRIP, // Final trip output
    output logic CTRL_ERR, // One-cycle termination timeout event
    output boc_pkg::boc_pos_t OBJ_STATUS, // Object position status
    output boc_pkg::boc_pos_t CART_STATUS // Cart position status
);
    import boc_pkg::*;

    // ------------------------------------------------------------------
    // Millisecond tick and position monitors
    // ------------------------------------------------------------------
    logic tick;
    logic [14:0] trav_q;
    boc_pos_if obj_pos();
    boc_pos_if cart_pos();

    boc_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .tick(tick)
    );

    // One traverse setting serves both object and cart
    assign obj_pos.open_in = OPEN_ST;
    assign obj_pos.close_in = CLOSE_ST;
    assign obj_pos.trav = trav_q;
    assign cart_pos.open_in = CART_WITHDRAWN_IN;
    assign cart_pos.close_in = CART_INSERTED_IN;
    assign cart_pos.trav = trav_q;

    boc_pos_mon u_obj (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .tick(tick),
        .pos(obj_pos.mon)
    );

    boc_pos_mon u_cart (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .tick(tick),
        .pos(cart_pos.mon)
    );

    assign OBJ_STATUS = obj_pos.status;
    assign CART_STATUS = cart_pos.status;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic sync_use_q;
    logic [1:0] rdy_mode_q;
    logic [1:0] acc_q;
    logic [2:0] src_en_q;
    logic clr_q;
    logic [14:0] cpulse_q, opulse_q, term_q, ftrip_set_q;
    logic [31:0] stat_q [4];
    logic [3:0] inc;
    logic [31:0] rd_mux;

    // APB decode; zero wait states, error on unmapped words
    wire setup = PSEL && !PENABLE;
    wire wr = PSEL && PENABLE && PWRITE;
    wire hit_ctrl = PADDR == `BOC_ADDR_CTRL;
    wire hit_cmd = PADDR == `BOC_ADDR_CMD;
    wire hit_trav = PADDR == `BOC_ADDR_TRAV;
    wire hit_cpul = PADDR == `BOC_ADDR_CPULSE;
    wire hit_opul = PADDR == `BOC_ADDR_OPULSE;
    wire hit_term = PADDR == `BOC_ADDR_TERM;
    wire hit_ftrp = PADDR == `BOC_ADDR_FTRIP;
    wire hit_stat = PADDR == `BOC_ADDR_STATUS;
    // Four counter words share one 16-byte slot
    wire hit_cnt = (PADDR[7:4] == 4'(`BOC_ADDR_STAT0 >> 4)) && (PADDR[1:0] == 2'h0);
    wire hit = hit_ctrl | hit_cmd | hit_trav | hit_cpul | hit_opul | hit_term
             | hit_ftrp | hit_stat | hit_cnt;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;

    // Settings writes
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sync_use_q <= 1'b0;
            rdy_mode_q <= `BOC_RST_RDY;
            acc_q <= `BOC_RST_ACC;
            src_en_q <= `BOC_RST_SRC;
            trav_q <= `BOC_RST_TRAV;
            cpulse_q <= `BOC_RST_CPULSE;
            opulse_q <= `BOC_RST_OPULSE;
            term_q <= `BOC_RST_TERM;
            ftrip_set_q <= `BOC_RST_FTRIP;
        end else if (wr) begin
            if (hit_ctrl) begin
                sync_use_q <= PWDATA[`BOC_CTRL_SYNC];
                rdy_mode_q <= PWDATA[`BOC_CTRL_RDY_LSB +: 2];
                acc_q <= PWDATA[`BOC_CTRL_ACC_LSB +: 2];
                src_en_q <= PWDATA[`BOC_CTRL_SRC_LSB +: 3];
            end
            if (hit_trav) trav_q <= PWDATA[14:0];
            if (hit_cpul) cpulse_q <= PWDATA[14:0];
            if (hit_opul) opulse_q <= PWDATA[14:0];
            if (hit_term) term_q <= PWDATA[14:0];
            if (hit_ftrp) ftrip_set_q <= PWDATA[14:0];
        end
    end

    // Clear bit stays set for one cycle while the counters zero
    always_ff @(posedge CORE_CLK) begin
        if (!NRST)
            clr_q <= 1'b0;
        else
            clr_q <= wr && hit_ctrl && PWDATA[`BOC_CTRL_CLR] && !clr_q;
    end

    // Request counters; clear beats a simultaneous count
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_stat
            always_ff @(posedge CORE_CLK) begin
                if (!NRST || clr_q)
                    stat_q[gi] <= 32'h0;
                else if (inc[gi])
                    stat_q[gi] <= stat_q[gi] + 32'h1;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Command qualification
    // ------------------------------------------------------------------
    logic lvl_open_q, lvl_close_q;
    wire lvl_open = (LOC_OPEN && src_en_q[0]) || (REM_OPEN && src_en_q[1])
                  || (APP_OPEN && src_en_q[2]);
    wire lvl_close = (LOC_CLOSE && src_en_q[0]) || (REM_CLOSE && src_en_q[1])
                   || (APP_CLOSE && src_en_q[2]);
    // Panel commands need at least the required access level
    wire pnl_ok = wr && hit_cmd && (PWDATA[`BOC_CMD_LVL_LSB +: 2] >= acc_q);
    wire req_open = (lvl_open && !lvl_open_q) || (pnl_ok && PWDATA[`BOC_CMD_OPEN]);
    // Open wins when both directions arrive together
    wire req_close = !req_open && ((lvl_close && !lvl_close_q)
                   || (pnl_ok && PWDATA[`BOC_CMD_CLOSE]));
    wire ready_ok = (rdy_mode_q == BOC_RDY_HIGH) ? READY_ST :
                    (rdy_mode_q == BOC_RDY_LOW) ? !READY_ST : 1'b1;
    wire sync_ok = !sync_use_q || SYNC_OK;
    wire open_ok = !BLOCK_OPEN;
    wire close_ok = !BLOCK_CLOSE && sync_ok && ready_ok;

    // Edge detection of level sources
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            lvl_open_q <= 1'b0;
            lvl_close_q <= 1'b0;
        end else begin
            lvl_open_q <= lvl_open;
            lvl_close_q <= lvl_close;
        end
    end

    // ------------------------------------------------------------------
    // Control sequencer
    // ------------------------------------------------------------------
    boc_state_t st_q, st_d;
    logic [19:0] ms_q;
    logic open_d, close_d, err_d, ftrip_go;
    wire [19:0] olim = 20'(opulse_q) * `BOC_STEP_MS;
    wire [19:0] clim = 20'(cpulse_q) * `BOC_STEP_MS;
    wire [19:0] tlim = 20'(term_q) * `BOC_STEP_MS;
    wire at_open = OBJ_STATUS == BOC_POS_OPEN;
    wire at_closed = OBJ_STATUS == BOC_POS_CLOSED;
    wire timed_out = ms_q >= tlim;

    // Next state; a refused command never leaves idle
    always_comb begin
        st_d = st_q;
        open_d = OPEN_CMD;
        close_d = CLOSE_CMD;
        err_d = 1'b0;
        inc = 4'h0;
        ftrip_go = 1'b0;
        unique case (st_q)
            BOC_ST_IDLE: begin
                if (req_open && open_ok) begin
                    st_d = BOC_ST_OPENING;
                    open_d = 1'b1;
                end else if (req_close && close_ok) begin
                    st_d = BOC_ST_CLOSING;
                    close_d = 1'b1;
                end
                inc[2] = req_open && !open_ok;
                inc[3] = req_close && !close_ok;
            end
            BOC_ST_OPENING: begin
                if (at_open) begin
                    st_d = BOC_ST_IDLE;
                    open_d = 1'b0;
                    inc[0] = 1'b1;
                    ftrip_go = !RECLOSE_PENDING;
                end else if (timed_out) begin
                    st_d = BOC_ST_IDLE;
                    open_d = 1'b0;
                    err_d = 1'b1;
                    inc[2] = 1'b1;
                end else if (ms_q >= olim) begin
                    open_d = 1'b0;
                end
            end
            BOC_ST_CLOSING: begin
                if (at_closed) begin
                    st_d = BOC_ST_IDLE;
                    close_d = 1'b0;
                    inc[1] = 1'b1;
                end else if (timed_out) begin
                    st_d = BOC_ST_IDLE;
                    close_d = 1'b0;
                    err_d = 1'b1;
                    inc[3] = 1'b1;
                end else if (ms_q >= clim) begin
                    close_d = 1'b0;
                end
            end
            default: begin
                st_d = BOC_ST_IDLE;
                open_d = 1'b0;
                close_d = 1'b0;
            end
        endcase
    end

    // Sequencer registers; elapsed time restarts with each command
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            st_q <= BOC_ST_IDLE;
            ms_q <= 20'h0;
            OPEN_CMD <= 1'b0;
            CLOSE_CMD <= 1'b0;
            CTRL_ERR <= 1'b0;
        end else begin
            st_q <= st_d;
            OPEN_CMD <= open_d;
            CLOSE_CMD <= close_d;
            CTRL_ERR <= err_d;
            if (st_q == BOC_ST_IDLE)
                ms_q <= 20'h0;
            else if (tick)
                ms_q <= ms_q + 20'h1;
        end
    end

    // ------------------------------------------------------------------
    // Final trip
    // ------------------------------------------------------------------
    logic [19:0] fms_q;
    wire [19:0] flim = 20'(ftrip_set_q) * `BOC_STEP_MS;
    // Zero length latches until the next successful close
    wire ftrip_end = (flim != 20'h0) ? (fms_q >= flim) : inc[1];

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            FINAL_TRIP <= 1'b0;
            fms_q <= 20'h0;
        end else if (ftrip_go) begin
            FINAL_TRIP <= 1'b1;
            fms_q <= 20'h0;
        end else if (FINAL_TRIP) begin
            FINAL_TRIP <= !ftrip_end;
            if (tick)
                fms_q <= fms_q + 20'h1;
        end
    end

    // ------------------------------------------------------------------
    // Read path; data registered in the setup phase
    // ------------------------------------------------------------------
    wire [31:0] status_w = {20'h0, sync_ok, ready_ok, BLOCK_CLOSE, BLOCK_OPEN,
                            FINAL_TRIP, CLOSE_CMD, OPEN_CMD, 1'b0, CART_STATUS, OBJ_STATUS};
    assign rd_mux = hit_ctrl ? {23'h0, clr_q, src_en_q, acc_q, rdy_mode_q, sync_use_q} :
                    hit_trav ? {17'h0, trav_q} :
                    hit_cpul ? {17'h0, cpulse_q} :
                    hit_opul ? {17'h0, opulse_q} :
                    hit_term ? {17'h0, term_q} :
                    hit_ftrp ? {17'h0, ftrip_set_q} :
                    hit_stat ? status_w :
                    hit_cnt ? stat_q[PADDR[3:2]] : 32'h0;

    always_ff @(posedge CORE_CLK) begin
        if (!NRST)
            PRDATA <= 32'h0;
        else if (setup)
            PRDATA <= rd_mux;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    AST_ONE_DIRECTION: assert property (!(OPEN_CMD && CLOSE_CMD))
        else $error("open and close commands active together");
    AST_OPEN_LIMIT: assert property (OPEN_CMD |-> ms_q <= olim)
        else $error("open pulse exceeded its length");
    AST_CLOSE_LIMIT: assert property (CLOSE_CMD |-> ms_q <= clim)
        else $error("close pulse exceeded its length");
    AST_SYNC_GATE: assert property ($rose(CLOSE_CMD) |-> $past(sync_ok))
        else $error("close issued without sync permission");
    AST_READY_GATE: assert property ($rose(CLOSE_CMD) |-> $past(ready_ok))
        else $error("close issued without ready condition");
    AST_REFUSE_OPEN: assert property (
        st_q == BOC_ST_IDLE && req_open && BLOCK_OPEN && !clr_q
        |=> !OPEN_CMD && stat_q[2] == $past(stat_q[2]) + 32'h1)
        else $error("blocked open not refused and counted");
    AST_TIMEOUT: assert property (
        st_q == BOC_ST_OPENING && !at_open && timed_out
        |=> CTRL_ERR && !OPEN_CMD && st_q == BOC_ST_IDLE)
        else $error("termination timeout not taken");
    AST_CLEAR: assert property (clr_q |=> stat_q[0] == 32'h0 && stat_q[3] == 32'h0 && !clr_q)
        else $error("clear did not zero counters");
    AST_BAD_CAUSE: assert property (
        OBJ_STATUS == BOC_POS_BAD && $changed(OBJ_STATUS) |-> $past(OPEN_ST && CLOSE_ST))
        else $error("bad status without both inputs");
    AST_OPEN_SEEN: assert property (OPEN_ST && !CLOSE_ST |=> OBJ_STATUS == BOC_POS_OPEN)
        else $error("open input not reported");
    AST_FTRIP_CAUSE: assert property ($rose(FINAL_TRIP) |-> $past(!RECLOSE_PENDING))
        else $error("final trip while reclose expected");

    COV_OPEN_DONE: cover property (st_q == BOC_ST_OPENING ##1 st_q == BOC_ST_IDLE && !CTRL_ERR);
    COV_CLOSE_DONE: cover property ($fell(CLOSE_CMD) && at_closed);
    COV_TIMEOUT: cover property (CTRL_ERR);
    COV_FTRIP: cover property ($fell(FINAL_TRIP));
endmodule

// ---- tb/boc_brk_model.sv ----
// Breaker model driven by the relay command pulses.
// Assumes pulses registered on the core clock; starts closed.
`timescale 1ns/1ps
module boc_brk_model #(
    parameter int DLY = 20
) (
    input wire logic clk, // Core clock
    input wire logic open_cmd, // Open pulse
    input wire logic close_cmd, // Close pulse
    output logic open_st, // 1 when open
    output logic close_st // 1 when closed
);
    int cnt = 0;
    initial begin
        open_st = 1'b0;
        close_st = 1'b1;
    end
    // Contacts move once a pulse has lasted DLY cycles; a short pulse moves nothing
    always @(posedge clk) begin
        cnt <= (open_cmd || close_cmd) ? cnt + 1 : 0;
        if (cnt == DLY) begin
            open_st <= open_cmd;
            close_st <= close_cmd;
        end
    end
endmodule

// ---- tb/boc_object_ctrl_tb.sv ----
// Testbench: APB tasks and command sequences on the object controller.
// Assumes a 4-cycle ms tick and the breaker model on the relays.
`timescale 1ns/1ps
module boc_object_ctrl_tb;
    import boc_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, serr, lerr, pready;
    logic [7:0] padr = 0;
    logic [31:0] pwd = 0, prd, rv;
    logic ost, cst, ocmd, ccmd, ftrip, cerr;
    logic lo = 0, lc = 0, ro = 0, rc = 0, ao = 0, ac = 0, bo = 0, bc = 0, rp = 0;
    logic ci = 0, cw = 0, rdy = 0, syn = 0;
    boc_pos_t obj, cart;
    int err_total = 0, checks_done = 0, cyc = 0;
    boc_object_ctrl #(.TICK_CYCLES(4)) DUT (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(pready), .PSLVERR(serr), .OPEN_ST(ost), .CLOSE_ST(cst),
        .CART_INSERTED_IN(ci), .CART_WITHDRAWN_IN(cw), .READY_ST(rdy), .SYNC_OK(syn),
        .LOC_OPEN(lo), .LOC_CLOSE(lc), .REM_OPEN(ro), .REM_CLOSE(rc), .APP_OPEN(ao),
        .APP_CLOSE(ac), .BLOCK_OPEN(bo), .BLOCK_CLOSE(bc), .RECLOSE_PENDING(rp),
        .OPEN_CMD(ocmd), .CLOSE_CMD(ccmd), .FINAL_TRIP(ftrip), .CTRL_ERR(cerr),
        .OBJ_STATUS(obj), .CART_STATUS(cart));
    boc_brk_model #(.DLY(20)) BRK (.clk(clk), .open_cmd(ocmd), .close_cmd(ccmd),
        .open_st(ost), .close_st(cst));
    // Clock and hang guard; the ceiling is well above the whole sequence
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, s);
            err_total++;
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prd;
        lerr = serr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rv);
    endtask
    // Waits a bounded time for the object status, then compares it
    task automatic wpos(input boc_pos_t s);
        for (int i = 0; i < 3000 && obj !== s; i++) @(posedge clk);
        chk("obj", 32'(s), 32'(obj));
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        rdc("ctrl", 8'h00, 32'h000000f4);
        rdc("trav", 8'h08, 32'h0000000a);
        rdc("term", 8'h14, 32'h000001f4);
        rdc("hole", 8'h40, 32'h0);
        chk("slverr", 32'h1, 32'(lerr));
        $display("test defaults done");
        ci <= 1;
        lo <= 1;
        repeat (3) @(posedge clk);
        #1 chk("ocmd", 32'h1, 32'(ocmd));
        @(posedge clk);
        lo <= 0;
        wpos(BOC_POS_OPEN);
        repeat (3) @(posedge clk);
        #1 chk("ocmd", 32'h0, 32'(ocmd));
        chk("ftrip", 32'h1, 32'(ftrip));
        chk("cart", 32'(BOC_POS_CLOSED), 32'(cart));
        rdc("open ok", 8'h20, 32'h1);
        $display("test open done");
        // Blocks lead the requests by more than 5 ms (20 cycles)
        bo <= 1;
        bc <= 1;
        repeat (24) @(posedge clk);
        lo <= 1;
        @(posedge clk);
        lc <= 1;
        repeat (4) @(posedge clk);
        #1 chk("cmds", 32'h0, {30'h0, ocmd, ccmd});
        rdc("open fail", 8'h28, 32'h1);
        rdc("close fail", 8'h2c, 32'h1);
        lo <= 0;
        lc <= 0;
        bo <= 0;
        bc <= 0;
        $display("test blocked done");
        // Let the released local close settle so the remote close is a fresh edge
        @(posedge clk);
        rc <= 1;
        wpos(BOC_POS_CLOSED);
        rc <= 0;
        rdc("close ok", 8'h24, 32'h1);
        // Panel open below the required level is dropped
        apb(1'b1, 8'h04, 32'h00000005);
        repeat (6) @(posedge clk);
        #1 chk("panel", 32'h0, 32'(ocmd));
        rp <= 1;
        ao <= 1;
        wpos(BOC_POS_OPEN);
        ao <= 0;
        rdc("open ok", 8'h20, 32'h2);
        $display("test sources done");
        // Short timings, cart both in and out, sync and ready-high in use
        apb(1'b1, 8'h08, 32'h00000001);
        cw <= 1;
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h14, 32'h00000001);
        apb(1'b1, 8'h00, 32'h000000f1);
        rc <= 1;
        repeat (4) @(posedge clk);
        #1 chk("sync", 32'h0, 32'(ccmd));
        @(posedge clk);
        rc <= 0;
        syn <= 1;
        rdy <= 1;
        // Panel close at the required level; a one-cycle pulse cannot move the breaker
        apb(1'b1, 8'h04, 32'h0000000a);
        for (int i = 0; i < 300 && cerr !== 1'b1; i++) @(posedge clk);
        chk("cerr", 32'h1, 32'(cerr));
        rdc("close fail", 8'h2c, 32'h3);
        chk("cart", 32'(BOC_POS_BAD), 32'(cart));
        $display("test timeout done");
        apb(1'b1, 8'h00, 32'h000001f4);
        repeat (2) @(posedge clk);
        rdc("cleared", 8'h20, 32'h0);
        rdc("ctrl", 8'h00, 32'h000000f4);
        $display("test clear done");
        stop_test();
    end
endmodule
